// file: shared/atw_params.svh
/*
 Constants of the asynchronous timer waveform block: register offsets,
 reset values, mode and clock-select codes, prescaler taps.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef ATW_PARAMS_SVH
`define ATW_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ATW_OFS_CTRL_A 8'hB0
`define ATW_OFS_CTRL_B 8'hB1
`define ATW_OFS_COUNT 8'hB2
`define ATW_OFS_CMP_A 8'hB3
`define ATW_OFS_CMP_B 8'hB4
`define ATW_OFS_ASYNC 8'hB6
`define ATW_OFS_FLAGS 8'hB7
`define ATW_OFS_GTC 8'h43

// ----------------------------------------
// Values
// ----------------------------------------
`define ATW_RST_BYTE 8'h00
`define ATW_MAX 8'hFF
`define ATW_BOTTOM 8'h00
`define ATW_STEP 8'h01
`define ATW_PRESC_W 10
`define ATW_PRESC_ZERO 10'h000
`define ATW_PRESC_STEP 10'h001

// ----------------------------------------
// Waveform mode codes
// ----------------------------------------
`define ATW_WGM_NORMAL 3'h0
`define ATW_WGM_PC_FF 3'h1
`define ATW_WGM_CTC 3'h2
`define ATW_WGM_FAST_FF 3'h3
`define ATW_WGM_RSVD4 3'h4
`define ATW_WGM_PC_OCR 3'h5
`define ATW_WGM_RSVD6 3'h6
`define ATW_WGM_FAST_OCR 3'h7

// ----------------------------------------
// Compare output codes
// ----------------------------------------
`define ATW_COM_OFF 2'h0
`define ATW_COM_TOGGLE 2'h1
`define ATW_COM_CLEAR 2'h2
`define ATW_COM_SET 2'h3

// ----------------------------------------
// Clock select codes and taps
// ----------------------------------------
`define ATW_CS_STOP 3'h0
`define ATW_CS_DIV1 3'h1
`define ATW_CS_DIV8 3'h2
`define ATW_CS_DIV32 3'h3
`define ATW_CS_DIV64 3'h4
`define ATW_CS_DIV128 3'h5
`define ATW_CS_DIV256 3'h6
`define ATW_CS_DIV1024 3'h7
`define ATW_TAP8 10'h007
`define ATW_TAP32 10'h01F
`define ATW_TAP64 10'h03F
`define ATW_TAP128 10'h07F
`define ATW_TAP256 10'h0FF
`define ATW_TAP1024 10'h3FF

`endif

// file: shared/atw_pkg.sv
/*
 Types of the asynchronous timer waveform block: register layouts,
 mode classes and the whole module state.
 Assumes atw_params.svh is on the include path.
*/
`include "atw_params.svh"

package atw_pkg;

    // ----------------------------------------
    // Register layouts
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [1:0] rsvd;
        logic [1:0] wgm_low;
    } atw_ctrl_a_t;

    typedef struct packed {
        logic force_a;
        logic force_b;
        logic [1:0] rsvd;
        logic wgm_high;
        logic [2:0] cs;
    } atw_ctrl_b_t;

    typedef struct packed {
        logic rsvd;
        logic ext_clk;
        logic async_sel;
        logic [4:0] busy;
    } atw_async_t;

    typedef struct packed {
        logic [6:0] rsvd;
        logic psr;
    } atw_gtc_t;

    typedef struct packed {
        logic [4:0] rsvd;
        logic match_b;
        logic match_a;
        logic ovf;
    } atw_flags_t;

    typedef enum logic [1:0] {
        ATW_KIND_NONPWM,
        ATW_KIND_PC,
        ATW_KIND_FAST
    } atw_kind_t;

    // ----------------------------------------
    // Module state
    // ----------------------------------------
    typedef struct packed {
        atw_ctrl_a_t ctrl_a;
        atw_ctrl_b_t ctrl_b;
        logic async_sel;
        logic ext_clk;
        logic [7:0] cnt;
        logic [7:0] ocr_a;
        logic [7:0] ocr_b;
        logic [7:0] ocr_a_act;
        logic [7:0] ocr_b_act;
        logic count_up;
        logic block_match;
        logic [`ATW_PRESC_W-1:0] presc;
        atw_flags_t flags;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic out_a;
        logic out_b;
        logic oe_a;
        logic oe_b;
        logic detach;
        logic xtal_en;
        logic ext_buf_en;
        logic [7:0] rd_data;
    } atw_state_t;

endpackage

// file: hw/atw_timer.sv
/*
 Clock source, prescaler, counter and compare-output waveform logic of an
 8-bit timer with two compare channels and an optional asynchronous source.
 Assumes a plain register port with read data one cycle after the strobe,
 pin direction bits from the port logic, and a slow oscillator pin level.
*/
// Design decision made here: the address-and-strobe port.
// Functional notes
// - Timer source is the core clock, or the oscillator pin when async selected.
// - Async selection detaches both oscillator pins from their port function.
// - External clock enable takes a 32kHz clock on the pin, crystal off.
// - Prescaler offers divide 8, 32, 64, 128, 256, 1024, undivided and stop.
// - Prescaler reset bit clears the prescaler for a predictable phase.
// - Control A bits 3:2 read zero and ignore writes.
// - Channel A nonzero mode overrides port; driver needs its direction bit.
// - Channel B nonzero mode overrides port; driver needs its direction bit.
// - Non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM A: 10 clear on match, set at bottom; 11 inverse; 01 toggle in mode 7 only.
// - Fast PWM B: 01 reserved; 10 non-inverting; 11 inverting.
// - Phase-correct A: 10 clear up, set down; 11 reverse; 01 toggle in mode 5 only.
// - Phase-correct B: 01 reserved; 10 clear up, set down; 11 opposite.
// - Fast PWM 10 or 11 with compare equal TOP: match ignored, action at bottom.
// - Phase-correct 10 or 11 with compare equal TOP: match ignored, action at TOP.
// - Waveform mode is high bit joined with control A bits 1:0.
// - Mode 0 counts to 0xFF, immediate compare update, overflow at MAX.
// - Mode 2 uses compare A as TOP, immediate update, overflow at MAX.
// - Modes 1 and 5 phase-correct, buffer update at TOP, overflow at bottom.
// - Modes 3 and 7 fast, buffer update at bottom, overflow MAX or TOP.
// - Clock select 000 stops, 001 undivided, 010 to 111 prescaled taps.
// - Force strobe applies compare action in non-PWM, no flag, reads zero.
`timescale 1ns/10ps
`include "atw_params.svh"

module atw_timer
    import atw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rd_data,
    input wire logic osc_input_pin,
    input wire logic pin_dir_a,
    input wire logic pin_dir_b,
    output logic compare_output_a,
    output logic compare_output_a_oe,
    output logic compare_output_b,
    output logic compare_output_b_oe,
    output logic osc_pins_detach,
    output logic osc_crystal_enable,
    output logic osc_ext_clock_enable
);

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic atw_kind_t mode_kind(input logic [2:0] wgm);
        unique case (wgm)
            `ATW_WGM_PC_FF, `ATW_WGM_PC_OCR: mode_kind = ATW_KIND_PC;
            `ATW_WGM_FAST_FF, `ATW_WGM_FAST_OCR: mode_kind = ATW_KIND_FAST;
            default: mode_kind = ATW_KIND_NONPWM;
        endcase
    endfunction

    function automatic logic tap_hit(input logic [`ATW_PRESC_W-1:0] p, input logic [2:0] cs);
        unique case (cs)
            `ATW_CS_STOP: tap_hit = 1'b0;
            `ATW_CS_DIV1: tap_hit = 1'b1;
            `ATW_CS_DIV8: tap_hit = (p & `ATW_TAP8) == `ATW_TAP8;
            `ATW_CS_DIV32: tap_hit = (p & `ATW_TAP32) == `ATW_TAP32;
            `ATW_CS_DIV64: tap_hit = (p & `ATW_TAP64) == `ATW_TAP64;
            `ATW_CS_DIV128: tap_hit = (p & `ATW_TAP128) == `ATW_TAP128;
            `ATW_CS_DIV256: tap_hit = (p & `ATW_TAP256) == `ATW_TAP256;
            `ATW_CS_DIV1024: tap_hit = (p & `ATW_TAP1024) == `ATW_TAP1024;
        endcase
    endfunction

    // Next compare-output level of one channel
    function automatic logic wave_next(
        input logic cur,
        input logic [1:0] com,
        input logic is_b,
        input logic whigh,
        input atw_kind_t kind,
        input logic match,
        input logic top_ev,
        input logic bot_ev,
        input logic up,
        input logic ocr_top
    );
        logic r;
        r = cur;
        unique case (kind)
            ATW_KIND_NONPWM: begin
                if (match) begin
                    unique case (com)
                        `ATW_COM_OFF: r = cur;
                        `ATW_COM_TOGGLE: r = ~cur;
                        `ATW_COM_CLEAR: r = 1'b0;
                        `ATW_COM_SET: r = 1'b1;
                    endcase
                end
            end
            ATW_KIND_FAST: begin
                if (com == `ATW_COM_TOGGLE) begin
                    if (!is_b && whigh && match) begin
                        r = ~cur;
                    end
                end else if (com[1]) begin
                    if (match && !ocr_top) begin
                        r = com[0];
                    end
                    if (bot_ev) begin
                        r = ~com[0];
                    end
                end
            end
            ATW_KIND_PC: begin
                if (com == `ATW_COM_TOGGLE) begin
                    if (!is_b && whigh && match) begin
                        r = ~cur;
                    end
                end else if (com[1]) begin
                    if (match && !ocr_top) begin
                        r = up ? com[0] : ~com[0];
                    end
                    if (top_ev && ocr_top) begin
                        r = ~com[0];
                    end
                end
            end
            default: r = cur;
        endcase
        wave_next = r;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    atw_state_t st;
    atw_state_t next_st;

    logic [2:0] wgm;
    atw_kind_t kind;
    logic [7:0] top;
    logic src_tick;
    logic t_tick;
    logic psr_wr;
    logic cnt_wr;
    logic force_a;
    logic force_b;
    logic match_a;
    logic match_b;
    logic top_ev;
    logic bot_ev;
    logic ovf_ev;
    logic upd_ev;
    atw_gtc_t wr_gtc;
    atw_ctrl_b_t wr_ctrl_b;
    atw_async_t wr_async;

    always_comb begin
        next_st = st;
        next_st.rd_data = `ATW_RST_BYTE;
        wr_gtc = atw_gtc_t'(reg_wr_data);
        wr_ctrl_b = atw_ctrl_b_t'(reg_wr_data);
        wr_async = atw_async_t'(reg_wr_data);
        wgm = {st.ctrl_b.wgm_high, st.ctrl_a.wgm_low};
        kind = mode_kind(wgm);
        top = (wgm == `ATW_WGM_CTC || wgm == `ATW_WGM_PC_OCR || wgm == `ATW_WGM_FAST_OCR) ?
              st.ocr_a_act : `ATW_MAX;

        // Oscillator pin synchroniser and source select
        next_st.osc_s1 = osc_input_pin;
        next_st.osc_s2 = st.osc_s1;
        next_st.osc_s3 = st.osc_s2;
        src_tick = st.async_sel ? (st.osc_s2 & ~st.osc_s3) : 1'b1;

        // Prescaler
        psr_wr = reg_wr && reg_addr == `ATW_OFS_GTC && wr_gtc.psr;
        t_tick = src_tick && !psr_wr && tap_hit(st.presc, st.ctrl_b.cs);
        if (psr_wr) begin
            next_st.presc = `ATW_PRESC_ZERO;
        end else if (src_tick) begin
            next_st.presc = st.presc + `ATW_PRESC_STEP;
        end

        // Counter
        cnt_wr = reg_wr && reg_addr == `ATW_OFS_COUNT;
        match_a = t_tick && !st.block_match && st.cnt == st.ocr_a_act;
        match_b = t_tick && !st.block_match && st.cnt == st.ocr_b_act;
        top_ev = t_tick && st.cnt == top;
        bot_ev = 1'b0;
        ovf_ev = 1'b0;
        upd_ev = 1'b0;
        if (t_tick) begin
            next_st.block_match = 1'b0;
            unique case (kind)
                ATW_KIND_NONPWM: begin
                    ovf_ev = st.cnt == `ATW_MAX;
                    if (wgm == `ATW_WGM_CTC && st.cnt == st.ocr_a_act) begin
                        next_st.cnt = `ATW_BOTTOM;
                    end else begin
                        next_st.cnt = st.cnt + `ATW_STEP;
                    end
                end
                ATW_KIND_FAST: begin
                    if (st.cnt == top) begin
                        next_st.cnt = `ATW_BOTTOM;
                        bot_ev = 1'b1;
                        upd_ev = 1'b1;
                        ovf_ev = 1'b1;
                    end else begin
                        next_st.cnt = st.cnt + `ATW_STEP;
                    end
                end
                ATW_KIND_PC: begin
                    if (st.count_up) begin
                        if (st.cnt == top) begin
                            upd_ev = 1'b1;
                            if (top != `ATW_BOTTOM) begin
                                next_st.count_up = 1'b0;
                                next_st.cnt = st.cnt - `ATW_STEP;
                            end
                        end else begin
                            next_st.cnt = st.cnt + `ATW_STEP;
                        end
                    end else if (st.cnt == `ATW_BOTTOM) begin
                        ovf_ev = 1'b1;
                        next_st.count_up = 1'b1;
                        next_st.cnt = st.cnt + `ATW_STEP;
                    end else begin
                        next_st.cnt = st.cnt - `ATW_STEP;
                    end
                end
                default: next_st.cnt = st.cnt;
            endcase
        end
        if (upd_ev) begin
            next_st.ocr_a_act = st.ocr_a;
            next_st.ocr_b_act = st.ocr_b;
        end

        // Waveform outputs
        force_a = reg_wr && reg_addr == `ATW_OFS_CTRL_B && wr_ctrl_b.force_a &&
                  kind == ATW_KIND_NONPWM;
        force_b = reg_wr && reg_addr == `ATW_OFS_CTRL_B && wr_ctrl_b.force_b &&
                  kind == ATW_KIND_NONPWM;
        next_st.out_a = wave_next(st.out_a, st.ctrl_a.com_a, 1'b0, st.ctrl_b.wgm_high, kind,
                                  match_a | force_a, top_ev, bot_ev, st.count_up, st.ocr_a_act == top);
        next_st.out_b = wave_next(st.out_b, st.ctrl_a.com_b, 1'b1, st.ctrl_b.wgm_high, kind,
                                  match_b | force_b, top_ev, bot_ev, st.count_up, st.ocr_b_act == top);
        next_st.oe_a = st.ctrl_a.com_a != `ATW_COM_OFF && pin_dir_a;
        next_st.oe_b = st.ctrl_a.com_b != `ATW_COM_OFF && pin_dir_b;

        // Oscillator pin control
        next_st.detach = st.async_sel;
        next_st.xtal_en = st.async_sel && !st.ext_clk;
        next_st.ext_buf_en = st.async_sel && st.ext_clk;

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `ATW_OFS_CTRL_A: begin
                    next_st.ctrl_a = atw_ctrl_a_t'(reg_wr_data);
                    next_st.ctrl_a.rsvd = '0;
                end
                `ATW_OFS_CTRL_B: begin
                    next_st.ctrl_b = atw_ctrl_b_t'(reg_wr_data);
                    next_st.ctrl_b.force_a = 1'b0;
                    next_st.ctrl_b.force_b = 1'b0;
                    next_st.ctrl_b.rsvd = '0;
                end
                `ATW_OFS_COUNT: begin
                    next_st.cnt = reg_wr_data;
                    next_st.block_match = 1'b1;
                end
                `ATW_OFS_CMP_A: begin
                    next_st.ocr_a = reg_wr_data;
                    if (kind == ATW_KIND_NONPWM) begin
                        next_st.ocr_a_act = reg_wr_data;
                    end
                end
                `ATW_OFS_CMP_B: begin
                    next_st.ocr_b = reg_wr_data;
                    if (kind == ATW_KIND_NONPWM) begin
                        next_st.ocr_b_act = reg_wr_data;
                    end
                end
                `ATW_OFS_ASYNC: begin
                    next_st.ext_clk = wr_async.ext_clk;
                    next_st.async_sel = wr_async.async_sel;
                end
                default: next_st.rd_data = `ATW_RST_BYTE;
            endcase
        end

        // Flags: hardware set wins over write-one clear
        if (reg_wr && reg_addr == `ATW_OFS_FLAGS) begin
            next_st.flags = st.flags & ~atw_flags_t'(reg_wr_data);
            next_st.flags.rsvd = '0;
        end
        if (ovf_ev) begin
            next_st.flags.ovf = 1'b1;
        end
        if (match_a) begin
            next_st.flags.match_a = 1'b1;
        end
        if (match_b) begin
            next_st.flags.match_b = 1'b1;
        end

        // Register reads
        if (reg_rd) begin
            unique case (reg_addr)
                `ATW_OFS_CTRL_A: next_st.rd_data = {st.ctrl_a.com_a, st.ctrl_a.com_b, 2'h0,
                                                    st.ctrl_a.wgm_low};
                `ATW_OFS_CTRL_B: next_st.rd_data = {4'h0, st.ctrl_b.wgm_high, st.ctrl_b.cs};
                `ATW_OFS_COUNT: next_st.rd_data = st.cnt;
                `ATW_OFS_CMP_A: next_st.rd_data = st.ocr_a;
                `ATW_OFS_CMP_B: next_st.rd_data = st.ocr_b;
                `ATW_OFS_ASYNC: next_st.rd_data = {1'b0, st.ext_clk, st.async_sel, 5'h00};
                `ATW_OFS_FLAGS: next_st.rd_data = {5'h00, st.flags.match_b, st.flags.match_a,
                                                   st.flags.ovf};
                default: next_st.rd_data = `ATW_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rd_data = st.rd_data;
    assign compare_output_a = st.out_a;
    assign compare_output_a_oe = st.oe_a;
    assign compare_output_b = st.out_b;
    assign compare_output_b_oe = st.oe_b;
    assign osc_pins_detach = st.detach;
    assign osc_crystal_enable = st.xtal_en;
    assign osc_ext_clock_enable = st.ext_buf_en;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    rsvd_read_a: assert property (reg_rd && reg_addr == `ATW_OFS_CTRL_A |=>
        reg_rd_data[3:2] == 2'h0 && reg_rd_data[1:0] == $past(st.ctrl_a.wgm_low))
        else $error("control A reserved bits not zero");
    force_toggle_a: assert property (force_a && st.ctrl_a.com_a == `ATW_COM_TOGGLE |=>
        compare_output_a != $past(compare_output_a))
        else $error("force strobe did not toggle output A");
    stop_hold_a: assert property (st.ctrl_b.cs == `ATW_CS_STOP && !cnt_wr |=> st.cnt == $past(st.cnt))
        else $error("counter moved while stopped");
    ovf_max_a: assert property (t_tick && kind == ATW_KIND_NONPWM && st.cnt == `ATW_MAX |=> st.flags.ovf)
        else $error("overflow flag missing at MAX");
    ctc_clear_a: assert property (t_tick && wgm == `ATW_WGM_CTC && st.cnt == st.ocr_a_act && !cnt_wr |=>
        st.cnt == `ATW_BOTTOM)
        else $error("CTC counter not cleared on match");
    pc_turn_a: assert property (t_tick && kind == ATW_KIND_PC && st.count_up && st.cnt == top &&
        top != `ATW_BOTTOM && !cnt_wr |=> !st.count_up ##1 !st.count_up[*1])
        else $error("phase correct did not turn at TOP");
    presc_clear_a: assert property (psr_wr |=> st.presc == `ATW_PRESC_ZERO)
        else $error("prescaler not reset");
    oe_a_drive_a: assert property (1'b1 |=> compare_output_a_oe ==
        ($past(st.ctrl_a.com_a) != `ATW_COM_OFF && $past(pin_dir_a)))
        else $error("output A driver enable wrong");
    oe_b_drive_a: assert property (1'b1 |=> compare_output_b_oe ==
        ($past(st.ctrl_a.com_b) != `ATW_COM_OFF && $past(pin_dir_b)))
        else $error("output B driver enable wrong");
    fast_bottom_a: assert property (bot_ev && kind == ATW_KIND_FAST && st.ctrl_a.com_a == `ATW_COM_CLEAR |=>
        compare_output_a)
        else $error("fast PWM output A not set at bottom");
    osc_mode_a: assert property (osc_pins_detach |-> osc_crystal_enable != osc_ext_clock_enable)
        else $error("oscillator pin mode inconsistent");

    fast_wrap_c: cover property (bot_ev && kind == ATW_KIND_FAST);
    pc_turn_c: cover property (top_ev && kind == ATW_KIND_PC && st.count_up);
    force_c: cover property (force_a);
    async_tick_c: cover property (st.async_sel && t_tick);

endmodule

// file: verif/atw_timer_tb.sv
/*
 Self-checking bench of the timer waveform block over its register port.
 Assumes the atw_pkg package and atw_params.svh are compiled first.
*/
`timescale 1ns/10ps
`include "atw_params.svh"

module atw_timer_tb
    import atw_pkg::*;
;
    // ----------------------------------------
    // Ports and counters
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rd_data;
    logic osc_input_pin = 1'b0;
    logic pin_dir_a = 1'b0;
    logic pin_dir_b = 1'b0;
    logic out_a, oe_a, out_b, oe_b, detach, xtal, extc;
    logic [7:0] v;
    int mismatches = 0;
    int check_count = 0;
    int ha, hb;

    always #5 core_clk = ~core_clk;

    atw_timer atw_timer_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .osc_input_pin(osc_input_pin),
        .pin_dir_a(pin_dir_a), .pin_dir_b(pin_dir_b), .compare_output_a(out_a), .compare_output_a_oe(oe_a),
        .compare_output_b(out_b), .compare_output_b_oe(oe_b), .osc_pins_detach(detach),
        .osc_crystal_enable(xtal), .osc_ext_clock_enable(extc));

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rd_data;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rng(input string n, input int lo, input int hi, input logic [31:0] s);
        check_count++;
        if ($isunknown(s) || s < lo || s > hi) begin
            mismatches++;
            $display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi, s);
        end
    endtask

    task automatic restart(input logic [7:0] b1);
        wr(`ATW_OFS_CTRL_B, 8'h00);
        wr(`ATW_OFS_COUNT, 8'h00);
        wr(`ATW_OFS_GTC, 8'h01);
        wr(`ATW_OFS_CTRL_B, b1);
    endtask

    task automatic measure(input int n);
        ha = 0;
        hb = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            if (out_a === 1'b1) ha++;
            if (out_b === 1'b1) hb++;
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #600us;
        mismatches++;
        give_verdict();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [1:0] com [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
        logic exp_o [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        int taps [6] = '{8, 32, 64, 128, 256, 1024};
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(`ATW_OFS_CTRL_A, v); chk("ctrl_a reset", 8'h00, v);
        rd(8'h20, v); chk("unmapped", 8'h00, v);
        wr(`ATW_OFS_CTRL_A, 8'hFC);
        rd(`ATW_OFS_CTRL_A, v); chk("ctrl_a reserved", 8'hF0, v);
        pin_dir_a <= 1'b1;
        pin_dir_b <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(`ATW_OFS_CTRL_A, {com[i], com[i], 4'h0});
            wr(`ATW_OFS_CTRL_B, 8'hC0);
            repeat (3) @(posedge core_clk);
            chk("force out a", {7'h0, exp_o[i]}, {7'h0, out_a});
            chk("force out b", {7'h0, exp_o[i]}, {7'h0, out_b});
            chk("oe a", 8'h01, {7'h0, oe_a});
        end
        rd(`ATW_OFS_CTRL_B, v); chk("force reads zero", 8'h00, v);
        pin_dir_a <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("oe a no dir", 8'h00, {7'h0, oe_a});
        chk("oe b dir", 8'h01, {7'h0, oe_b});
        wr(`ATW_OFS_CTRL_A, 8'h00);
        repeat (3) @(posedge core_clk);
        chk("oe b off", 8'h00, {7'h0, oe_b});
        pin_dir_a <= 1'b1;
        restart(8'h00);
        repeat (40) @(posedge core_clk);
        rd(`ATW_OFS_COUNT, v); chk("stopped count", 8'h00, v);
        restart(8'h01);
        repeat (20) @(posedge core_clk);
        rd(`ATW_OFS_COUNT, v); rng("div1 count", 20, 24, v);
        for (int i = 0; i < 6; i++) begin
            restart({5'h0, 3'(i + 2)});
            repeat (taps[i] * 4) @(posedge core_clk);
            rd(`ATW_OFS_COUNT, v); rng("prescaled count", 3, 4, v);
        end
        wr(`ATW_OFS_FLAGS, 8'hFF);
        restart(8'h01);
        wr(`ATW_OFS_COUNT, 8'hF0);
        repeat (30) @(posedge core_clk);
        rd(`ATW_OFS_FLAGS, v); chk("overflow set", 8'h01, v & 8'h01);
        wr(`ATW_OFS_FLAGS, 8'h01);
        rd(`ATW_OFS_FLAGS, v); chk("overflow clear", 8'h00, v & 8'h01);
        wr(`ATW_OFS_CTRL_A, 8'h02);
        wr(`ATW_OFS_CMP_A, 8'h09);
        wr(`ATW_OFS_COUNT, 8'h00);
        for (int i = 0; i < 5; i++) begin
            repeat (7) @(posedge core_clk);
            rd(`ATW_OFS_COUNT, v); rng("ctc count", 0, 9, v);
        end
        wr(`ATW_OFS_CMP_A, 8'h40);
        wr(`ATW_OFS_CMP_B, 8'hC0);
        wr(`ATW_OFS_CTRL_A, 8'hB3);
        repeat (300) @(posedge core_clk);
        measure(512); rng("fast a 10", 120, 140, ha); rng("fast b 11", 116, 136, hb);
        wr(`ATW_OFS_CTRL_A, 8'hE3);
        repeat (300) @(posedge core_clk);
        measure(512); rng("fast a 11", 372, 392, ha); rng("fast b 10", 376, 396, hb);
        wr(`ATW_OFS_CMP_A, 8'hFF);
        wr(`ATW_OFS_CTRL_A, 8'h83);
        repeat (300) @(posedge core_clk);
        measure(512); rng("fast a top", 512, 512, ha);
        wr(`ATW_OFS_CMP_A, 8'h40);
        wr(`ATW_OFS_CMP_B, 8'h40);
        wr(`ATW_OFS_CTRL_A, 8'hA1);
        repeat (600) @(posedge core_clk);
        measure(1020); rng("pc a 10", 246, 266, ha); rng("pc b 10", 246, 266, hb);
        wr(`ATW_OFS_CMP_A, 8'h3F);
        wr(`ATW_OFS_CMP_B, 8'h1F);
        wr(`ATW_OFS_CTRL_A, 8'h63);
        wr(`ATW_OFS_CTRL_B, 8'h09);
        repeat (400) @(posedge core_clk);
        measure(512); rng("fast7 a 01", 250, 262, ha); rng("fast7 b 10", 250, 262, hb);
        wr(`ATW_OFS_CMP_B, 8'h20);
        wr(`ATW_OFS_CTRL_A, 8'hB1);
        repeat (300) @(posedge core_clk);
        measure(1008); rng("pc5 a top", 1008, 1008, ha); rng("pc5 b 11", 490, 502, hb);
        wr(`ATW_OFS_CTRL_A, 8'h00);
        wr(`ATW_OFS_ASYNC, 8'h20);
        repeat (3) @(posedge core_clk);
        chk("detach", 8'h03, {6'h0, detach, xtal});
        restart(8'h01);
        repeat (10) begin
            repeat (8) @(posedge core_clk);
            osc_input_pin <= 1'b1;
            repeat (8) @(posedge core_clk);
            osc_input_pin <= 1'b0;
        end
        repeat (8) @(posedge core_clk);
        rd(`ATW_OFS_COUNT, v); rng("async count", 9, 10, v);
        wr(`ATW_OFS_ASYNC, 8'h60);
        repeat (3) @(posedge core_clk);
        chk("ext clock", 8'h05, {5'h0, extc, xtal, detach});
        rd(`ATW_OFS_ASYNC, v); chk("async reg", 8'h60, v);
        wr(`ATW_OFS_ASYNC, 8'h00);
        repeat (3) @(posedge core_clk);
        chk("sync again", 8'h00, {5'h0, extc, xtal, detach});
        give_verdict();
    end
endmodule
